// ### src/wcb_consts.vh
// Purpose: constants for the write combining buffer
// Assumes: included by bare name from design files
// Notes: line geometry, chunk geometry and port widths
`ifndef WCB_CONSTS_VH
`define WCB_CONSTS_VH

// ----------------------------------------------------------------
// line geometry
// ----------------------------------------------------------------
`define WCB_LINE_BYTES 64
`define WCB_LINE_BYTES_OLD 32
`define WCB_NUM_BUFS 4
`define WCB_BUF_IDX_W 2
`define WCB_ADDR_W 32
`define WCB_LINE_ADDR_W 27
`define WCB_BYTE_OFS_W 6
`define WCB_CHUNK_BYTES 8
`define WCB_CHUNKS_MAX 8
`define WCB_CHUNKS_OLD 4
`define WCB_CHUNK_IDX_W 3

// ----------------------------------------------------------------
// output fifo shape
// ----------------------------------------------------------------
`define WCB_FIFO_DEPTH 4
`define WCB_FIFO_AW 2
// burst flag + last + 27-bit line addr + chunk idx + 8 strobes + 64 data
`define WCB_FIFO_W 104

`endif

// ### src/wcb_fifo.v
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: single clock, synchronous active-low reset
// Notes: honest full and empty; clock enable freezes all state
`timescale 1ns/1ns
`default_nettype none
module wcb_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // clock and reset
    input wire clk_i,
    input wire reset_n_i,
    input wire clk_en_i,
    // fill side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    // drain side
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;

    // handshake terms
    assign in_ready_o = (count_reg != DEPTH[AW:0]);
    assign out_valid_o = (count_reg != {(AW+1){1'b0}});
    assign out_data_o = mem_reg[rd_ptr_reg];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // storage write
    always @(posedge clk_i) begin
        if (clk_en_i && push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    // pointers and occupancy
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else if (clk_en_i) begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### src/wcb_line.v
// Purpose: one combining line buffer: address, data and byte mask
// Assumes: single clock, synchronous active-low reset
// Notes: later stores to a byte overwrite earlier ones
`timescale 1ns/1ns
`default_nettype none
`include "wcb_consts.vh"
module wcb_line (
    // clock and reset
    input wire clk_i,
    input wire reset_n_i,
    input wire clk_en_i,
    // control
    input wire alloc_i,
    input wire merge_i,
    input wire release_i,
    input wire [`WCB_LINE_ADDR_W-1:0] line_addr_i,
    input wire [`WCB_CHUNK_IDX_W-1:0] chunk_i,
    input wire [7:0] strb_i,
    input wire [63:0] data_i,
    // state
    output reg busy_o,
    output reg [`WCB_LINE_ADDR_W-1:0] line_addr_o,
    output reg [`WCB_LINE_BYTES-1:0] mask_o,
    output wire [`WCB_LINE_BYTES*8-1:0] data_o
);
    reg [7:0] byte_reg [0:`WCB_LINE_BYTES-1];
    integer b;
    genvar g;

    // flatten bytes for the drain side
    generate
        for (g = 0; g < `WCB_LINE_BYTES; g = g + 1) begin : flat
            assign data_o[g*8 +: 8] = byte_reg[g];
        end
    endgenerate

    // byte storage, last write wins
    always @(posedge clk_i) begin
        if (clk_en_i && (alloc_i || merge_i)) begin
            for (b = 0; b < 8; b = b + 1) begin
                if (strb_i[b]) begin
                    byte_reg[{chunk_i, b[2:0]}] <= data_i[b*8 +: 8];
                end
            end
        end
    end

    // tag and valid mask
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            busy_o <= 1'b0;
            line_addr_o <= {`WCB_LINE_ADDR_W{1'b0}};
            mask_o <= {`WCB_LINE_BYTES{1'b0}};
        end else if (clk_en_i) begin
            if (release_i) begin
                busy_o <= 1'b0;
                mask_o <= {`WCB_LINE_BYTES{1'b0}};
            end else if (alloc_i || merge_i) begin
                busy_o <= 1'b1;
                if (alloc_i) begin
                    line_addr_o <= line_addr_i;
                end
                mask_o[chunk_i*8 +: 8] <= mask_o[chunk_i*8 +: 8] | strb_i;
            end
        end
    end
endmodule
`default_nettype wire

// ### src/wcb_top.v
// Purpose: write combining buffer between core stores and system bus
// Assumes: stores are 8-byte aligned words with byte strobes
// Notes: bus side is a valid/ready stream of 8-byte beats
//
// Behaviour
// - repeated stores to one byte keep only the newest value.
// - the buffer is apart from caches and store queue and ignores snoops.
// - there are several line buffers of 64 bytes, or 32 in the old mode.
// - stores fill one open buffer at a time; the code also merges a store into any undrained buffer of its line.
// - filled buffers may be drained whenever the device chooses.
// - a fully valid buffer leaves as one burst of the whole line; one completed in the cycle it is picked leaves as partials.
// - a buffer with any missing byte leaves as one partial write per chunk holding a valid byte.
// - a partial drain makes at most 4 writes for 32 bytes, 8 for 64 bytes.
// - drained buffers may reach the bus in any order.
// - partial writes of one buffer may reach the bus in any chunk order.
// - all valid bytes of one aligned 8-byte chunk go in one write.
// - a full buffer is always exactly one burst; a buffer completed in the cycle it is picked leaves as partials.
// - a serializing event forces every open buffer to drain.
`timescale 1ns/1ns
`default_nettype none
`include "wcb_consts.vh"
module wcb_top (
    // clock, reset, enable
    input wire clk_i,
    input wire reset_n_i,
    input wire clk_en_i,
    // configuration: high selects the 32-byte line
    input wire line_short_i,
    // core store port
    input wire st_valid_i,
    output reg st_ready_o,
    input wire [`WCB_ADDR_W-1:0] st_addr_i,
    input wire [7:0] st_strb_i,
    input wire [63:0] st_data_i,
    // serializing event strobe
    input wire serialize_i,
    output reg drained_o,
    // system bus write beats
    output reg bus_valid_o,
    input wire bus_ready_i,
    output reg bus_burst_o,
    output reg bus_last_o,
    output reg [`WCB_ADDR_W-1:0] bus_addr_o,
    output reg [7:0] bus_strb_o,
    output reg [63:0] bus_data_o
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    localparam ST_IDLE = 2'd0;
    localparam ST_SCAN = 2'd1;
    localparam ST_FREE = 2'd2;
    localparam NB = `WCB_NUM_BUFS;
    localparam LB = `WCB_LINE_BYTES;

    wire [NB-1:0] busy;
    wire [`WCB_LINE_ADDR_W-1:0] tag [0:NB-1];
    wire [LB-1:0] mask [0:NB-1];
    wire [LB*8-1:0] ldata [0:NB-1];
    reg [NB-1:0] alloc;
    reg [NB-1:0] merge;
    reg [NB-1:0] rel;

    reg [`WCB_BUF_IDX_W-1:0] open_reg;
    reg open_vld_reg;
    reg [1:0] state_reg;
    reg [`WCB_BUF_IDX_W-1:0] drn_reg;
    reg [`WCB_CHUNK_IDX_W-1:0] chk_reg;
    reg drn_burst_reg;
    reg flush_reg;

    wire [`WCB_LINE_ADDR_W-1:0] st_line;
    wire [`WCB_CHUNK_IDX_W-1:0] st_chunk;
    wire [`WCB_CHUNK_IDX_W-1:0] last_chunk;
    wire [LB-1:0] need_mask;
    reg hit;
    reg [`WCB_BUF_IDX_W-1:0] hit_idx;
    reg free_any;
    reg [`WCB_BUF_IDX_W-1:0] free_idx;
    reg take;
    reg new_open;
    integer i;

    wire f_ready;
    wire f_valid;
    wire [`WCB_FIFO_W-1:0] f_data;
    reg f_push;
    reg [`WCB_FIFO_W-1:0] f_in;
    wire [LB-1:0] dmask;
    wire [LB*8-1:0] dline;
    wire full_line;
    wire [7:0] cstrb;

    // ----------------------------------------------------------------
    // line buffers
    // ----------------------------------------------------------------
    // short lines use only the low 32 bytes of each buffer
    // the tag has one spare top bit, used only by the 32-byte line
    assign st_line = line_short_i ? st_addr_i[`WCB_ADDR_W-1:5]
                     : {1'b0, st_addr_i[`WCB_ADDR_W-1:6]};
    assign st_chunk = line_short_i ? {1'b0, st_addr_i[4:3]} : st_addr_i[5:3];
    assign last_chunk = line_short_i ? 3'd3 : 3'd7;
    assign need_mask = line_short_i ? {{32{1'b0}}, {32{1'b1}}} : {LB{1'b1}};

    genvar g;
    generate
        for (g = 0; g < NB; g = g + 1) begin : lines
            // separate storage, no snoop port at all
            wcb_line u_line (
                .clk_i(clk_i),
                .reset_n_i(reset_n_i),
                .clk_en_i(clk_en_i),
                .alloc_i(alloc[g]),
                .merge_i(merge[g]),
                .release_i(rel[g]),
                .line_addr_i(st_line),
                .chunk_i(st_chunk),
                .strb_i(st_strb_i),
                .data_i(st_data_i),
                .busy_o(busy[g]),
                .line_addr_o(tag[g]),
                .mask_o(mask[g]),
                .data_o(ldata[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // store acceptance
    // ----------------------------------------------------------------
    // hit on any undrained buffer of the line, else look for a free one
    always @* begin
        hit = 1'b0;
        hit_idx = open_reg;
        free_any = 1'b0;
        free_idx = {`WCB_BUF_IDX_W{1'b0}};
        for (i = NB - 1; i >= 0; i = i - 1) begin
            if (!busy[i]) begin
                free_any = 1'b1;
                free_idx = i[`WCB_BUF_IDX_W-1:0];
            end
        end
        // any undrained buffer of the line merges; a line sits twice only while one copy drains
        for (i = 0; i < NB; i = i + 1) begin
            if (busy[i] && tag[i] == st_line
                    && !(state_reg != ST_IDLE && drn_reg == i[`WCB_BUF_IDX_W-1:0])) begin
                hit = 1'b1;
                hit_idx = i[`WCB_BUF_IDX_W-1:0];
            end
        end
        take = st_valid_i && !flush_reg && !serialize_i && (hit || free_any);
        new_open = take && !hit;
        alloc = {NB{1'b0}};
        merge = {NB{1'b0}};
        if (take && hit) begin
            merge[hit_idx] = 1'b1;
        end
        if (new_open) begin
            alloc[free_idx] = 1'b1;
        end
    end

    // ready is registered: it acknowledges, one cycle later, a store already taken
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            st_ready_o <= 1'b0;
            open_reg <= {`WCB_BUF_IDX_W{1'b0}};
            open_vld_reg <= 1'b0;
        end else if (clk_en_i) begin
            st_ready_o <= take;
            if (new_open) begin
                open_reg <= free_idx;
                open_vld_reg <= 1'b1;
            end else if (serialize_i || flush_reg) begin
                open_vld_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // drain engine
    // ----------------------------------------------------------------
    assign dmask = mask[drn_reg];
    assign dline = ldata[drn_reg];
    assign full_line = ((dmask & need_mask) == need_mask);
    assign cstrb = dmask[chk_reg*8 +: 8];

    // build one beat; a partial beat carries its whole chunk
    always @* begin
        f_push = 1'b0;
        f_in = {drn_burst_reg, chk_reg == last_chunk,
                tag[drn_reg], chk_reg, cstrb, dline[chk_reg*64 +: 64]};
        rel = {NB{1'b0}};
        if (state_reg == ST_SCAN) begin
            f_push = drn_burst_reg || (cstrb != 8'h00);
        end
        if (state_reg == ST_FREE) begin
            rel[drn_reg] = 1'b1;
        end
    end

    // pick a buffer, walk its chunks, then release it
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_reg <= ST_IDLE;
            drn_reg <= {`WCB_BUF_IDX_W{1'b0}};
            chk_reg <= {`WCB_CHUNK_IDX_W{1'b0}};
            drn_burst_reg <= 1'b0;
            flush_reg <= 1'b0;
            drained_o <= 1'b0;
        end else if (clk_en_i) begin
            drained_o <= 1'b0;
            if (serialize_i) begin
                flush_reg <= 1'b1;
            end
            case (state_reg)
                ST_IDLE: begin
                    chk_reg <= {`WCB_CHUNK_IDX_W{1'b0}};
                    for (i = 0; i < NB; i = i + 1) begin
                        // drain any closed buffer or a fully valid open one, or all under flush
                        if (busy[i] && state_reg == ST_IDLE
                                && (flush_reg || !open_vld_reg
                                    || open_reg != i[`WCB_BUF_IDX_W-1:0]
                                    || (mask[i] & need_mask) == need_mask)) begin
                            drn_reg <= i[`WCB_BUF_IDX_W-1:0];
                            drn_burst_reg <= ((mask[i] & need_mask) == need_mask);
                            state_reg <= ST_SCAN;
                        end
                    end
                    // drained only once the fifo and the bus stage are empty too
                    if (flush_reg && busy == {NB{1'b0}} && !serialize_i
                            && !f_valid && !bus_valid_o) begin
                        flush_reg <= 1'b0;
                        drained_o <= 1'b1;
                    end
                end
                ST_SCAN: begin
                    if (!f_push || f_ready) begin
                        if (chk_reg == last_chunk) begin
                            state_reg <= ST_FREE;
                        end else begin
                            chk_reg <= chk_reg + 1'b1;
                        end
                    end
                end
                ST_FREE: begin
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // output fifo and bus registers
    // ----------------------------------------------------------------
    wcb_fifo #(
        .WIDTH(`WCB_FIFO_W),
        .DEPTH(`WCB_FIFO_DEPTH),
        .AW(`WCB_FIFO_AW)
    ) u_fifo (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .in_valid_i(f_push),
        .in_ready_o(f_ready),
        .in_data_i(f_in),
        .out_valid_o(f_valid),
        .out_ready_i(!bus_valid_o || bus_ready_i),
        .out_data_o(f_data)
    );

    // output stage holds a beat until the bus takes it
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            bus_valid_o <= 1'b0;
            bus_burst_o <= 1'b0;
            bus_last_o <= 1'b0;
            bus_addr_o <= {`WCB_ADDR_W{1'b0}};
            bus_strb_o <= 8'h00;
            bus_data_o <= 64'h0000_0000_0000_0000;
        end else if (clk_en_i && (!bus_valid_o || bus_ready_i)) begin
            bus_valid_o <= f_valid;
            if (f_valid) begin
                bus_burst_o <= f_data[103];
                bus_last_o <= f_data[102];
                bus_addr_o <= line_short_i
                    ? {f_data[101:75], f_data[73:72], 3'b000}
                    : {f_data[100:75], f_data[74:72], 3'b000};
                bus_strb_o <= f_data[71:64];
                bus_data_o <= f_data[63:0];
            end
        end
    end
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Purpose: self-checking bench for the write combining buffer
// Assumes: clock enable held high; stores are chunk aligned
// Notes: memory image is compared byte by byte after each flush
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic line_short_i = 1'b0;
    logic st_valid_i = 1'b0;
    logic serialize_i = 1'b0;
    logic [31:0] st_addr_i = 32'h0000_0000;
    logic [7:0] st_strb_i = 8'h00;
    logic [63:0] st_data_i = 64'h0000_0000_0000_0000;
    wire st_ready_o, drained_o, bus_valid_o, bus_ready_i, bus_burst_o, bus_last_o;
    wire [31:0] bus_addr_o;
    wire [7:0] bus_strb_o;
    wire [63:0] bus_data_o;
    int mismatches = 0;
    int n_compared = 0;
    int n_drained = 0;
    int b0 = 0;
    int p0 = 0;
    integer seed = 32'h0000_83f0;
    logic [7:0] exp_mem [int unsigned];

    // ----------------------------------------------------------------
    // clock, design, far side
    // ----------------------------------------------------------------
    always #25 clk_i = ~clk_i;

    wcb_top i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1),
        .line_short_i(line_short_i), .st_valid_i(st_valid_i), .st_ready_o(st_ready_o),
        .st_addr_i(st_addr_i), .st_strb_i(st_strb_i), .st_data_i(st_data_i),
        .serialize_i(serialize_i), .drained_o(drained_o), .bus_valid_o(bus_valid_o),
        .bus_ready_i(bus_ready_i), .bus_burst_o(bus_burst_o), .bus_last_o(bus_last_o),
        .bus_addr_o(bus_addr_o), .bus_strb_o(bus_strb_o), .bus_data_o(bus_data_o));

    wcb_bus_model i_bus (.clk_i(clk_i), .valid_i(bus_valid_o), .burst_i(bus_burst_o),
        .last_i(bus_last_o), .addr_i(bus_addr_o), .strb_i(bus_strb_o),
        .data_i(bus_data_o), .ready_o(bus_ready_i));

    // count drained pulses
    always @(posedge clk_i) begin
        if (drained_o === 1'b1) n_drained++;
    end

    function automatic int line_chunks(input logic short_line);
        return short_line ? 4 : 8;
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one store; hold > 0 expects that many refused cycles, then frees the bus
    task automatic store(input logic [31:0] a, input logic [7:0] s, input logic [63:0] d,
        input int hold);
        int n;
        @(posedge clk_i);
        #1 st_addr_i = a;
        st_strb_i = s;
        st_data_i = d;
        st_valid_i = 1'b1;
        for (n = 0; n < hold; n++) begin
            @(posedge clk_i);
            #1 check(st_ready_o, 1'b0);
        end
        if (hold > 0) i_bus.stall = 1'b0;
        n = 0;
        do begin
            @(posedge clk_i);
            #1 n++;
        end while (st_ready_o !== 1'b1 && n < 2000);
        check(st_ready_o, 1'b1);
        st_valid_i = 1'b0;
        for (n = 0; n < 8; n++) begin
            if (s[n]) exp_mem[a + n] = d[8*n +: 8];
        end
    endtask

    task automatic rand_store(input logic [31:0] base, input logic [31:0] span);
        logic [7:0] s;
        s = $random(seed);
        if (s == 8'h00) s = 8'h01;
        store(base + ($random(seed) & span & 32'hffff_fff8), s, {$random(seed), $random(seed)}, 0);
    endtask

    // serialize, wait for drained and an idle bus, then compare memory
    task automatic drain(input int bursts, input int max_parts);
        int n, idle;
        n = n_drained;
        @(posedge clk_i);
        #1 serialize_i = 1'b1;
        @(posedge clk_i);
        #1 serialize_i = 1'b0;
        idle = 0;
        for (int k = 0; k < 1000 && idle < 8; k++) begin
            @(posedge clk_i);
            #1 idle = (bus_valid_o !== 1'b1 && n_drained > n) ? idle + 1 : 0;
        end
        check(n_drained > n, 1'b1);
        foreach (exp_mem[a]) check(i_bus.mem.exists(a) ? i_bus.mem[a] : 8'hxx, exp_mem[a]);
        if (bursts >= 0) check(i_bus.bursts - b0, bursts);
        check(i_bus.partials - p0 <= max_parts, 1'b1);
        b0 = i_bus.bursts;
        p0 = i_bus.partials;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_i);
        #1 reset_n_i = 1'b1;
        // full long line, chunk zero written twice
        store(32'h0000_1000, 8'hff, 64'h0123_4567_89ab_cdef, 0);
        for (int i = 0; i < 8; i++) store(32'h0000_1000 + 8 * i, 8'hff, {$random(seed), $random(seed)}, 0);
        drain(1, 0);
        // same line again, one byte: mask was cleared by the drain
        store(32'h0000_1010, 8'h04, 64'h0000_0000_00aa_0000, 0);
        drain(0, 1);
        $display("test long_line done");
        // short lines: full burst then a fixed-strobe partial fill of three chunks
        line_short_i = 1'b1;
        for (int i = 0; i < 4; i++) store(32'h0000_2020 + 8 * i, 8'hff, {$random(seed), $random(seed)}, 0);
        drain(1, 0);
        for (int i = 0; i < 3; i++) store(32'h0000_2040 + 8 * i, 8'h3c, {$random(seed), $random(seed)}, 0);
        drain(0, line_chunks(1'b1));
        line_short_i = 1'b0;
        $display("test short_line done");
        // random stores over four long lines
        for (int i = 0; i < 60; i++) rand_store(32'h0000_3000, 32'h0000_00ff);
        drain(-1, 1000);
        $display("test random done");
        // stall the bus: four lines busy, a fifth store waits
        i_bus.stall = 1'b1;
        for (int i = 0; i < 32; i++) store(32'h0000_4000 + 8 * i, 8'h01, {$random(seed), $random(seed)}, 0);
        store(32'h0000_4400, 8'h80, {$random(seed), $random(seed)}, 12);
        drain(-1, 1000);
        $display("test stall done");
        conclude();
    end

    // watchdog
    initial begin
        #(50 * 60000);
        mismatches++;
        conclude();
    end
endmodule

bind wcb_top wcb_monitor i_mon (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .line_short_i(line_short_i), .st_valid_i(st_valid_i), .st_ready_o(st_ready_o),
    .serialize_i(serialize_i), .drained_o(drained_o), .bus_valid_o(bus_valid_o),
    .bus_ready_i(bus_ready_i), .bus_burst_o(bus_burst_o), .bus_last_o(bus_last_o),
    .bus_addr_o(bus_addr_o), .bus_strb_o(bus_strb_o), .bus_data_o(bus_data_o));
`default_nettype wire

// ### verif/wcb_bus_model.sv
// Purpose: system bus and memory model taking write beats
// Assumes: beats are taken on an edge with valid and ready high
// Notes: ready drawn at random; stall forces it low
`timescale 1ns/1ns
`default_nettype none
module wcb_bus_model (
    // clock
    input wire logic clk_i,
    // write beat
    input wire logic valid_i,
    input wire logic burst_i,
    input wire logic last_i,
    input wire logic [31:0] addr_i,
    input wire logic [7:0] strb_i,
    input wire logic [63:0] data_i,
    // acceptance
    output logic ready_o
);
    logic [7:0] mem [int unsigned];
    int bursts = 0;
    int partials = 0;
    bit stall = 1'b0;
    integer seed = 32'h0000_83f0;

    initial ready_o = 1'b0;

    // store beats by address, whatever the order of buffers and chunks
    always @(posedge clk_i) begin
        if (valid_i === 1'b1 && ready_o) begin
            for (int b = 0; b < 8; b++) begin
                if (strb_i[b]) mem[addr_i + b] = data_i[8*b +: 8];
            end
            if (burst_i && last_i) bursts++;
            if (!burst_i) partials++;
        end
        #1 ready_o <= !stall && ($random(seed) % 4 != 0);
    end
endmodule
`default_nettype wire

// ### verif/wcb_monitor.sv
// Purpose: port checker for the write combining buffer
// Assumes: single clock, synchronous active-low reset, clock enable high
// Notes: burst beats are expected in ascending chunk order
`timescale 1ns/1ns
`default_nettype none
module wcb_monitor (
    // clock and reset
    input wire clk_i,
    input wire reset_n_i,
    // configuration and core side
    input wire line_short_i,
    input wire st_valid_i,
    input wire st_ready_o,
    input wire serialize_i,
    input wire drained_o,
    // bus side
    input wire bus_valid_o,
    input wire bus_ready_i,
    input wire bus_burst_o,
    input wire bus_last_o,
    input wire [31:0] bus_addr_o,
    input wire [7:0] bus_strb_o,
    input wire [63:0] bus_data_o
);
    logic [3:0] burst_cnt;
    logic [31:0] burst_line;
    logic flushing;
    wire beat_take = bus_valid_o && bus_ready_i;

    // ----------------------------------------------------------------
    // helper state and assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    // burst beat counter and flush-in-progress flag
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            burst_cnt <= 4'h0;
            burst_line <= 32'h0000_0000;
            flushing <= 1'b0;
        end else begin
            if (beat_take && bus_burst_o) begin
                burst_cnt <= bus_last_o ? 4'h0 : burst_cnt + 4'h1;
                if (burst_cnt == 4'h0) burst_line <= bus_addr_o;
            end
            if (serialize_i) flushing <= 1'b1;
            else if (drained_o) flushing <= 1'b0;
        end
    end

    a_burst_strobe_full: assert property (bus_valid_o && bus_burst_o |-> bus_strb_o == 8'hff)
        else $error("burst beat with missing bytes");
    a_burst_start_chunk: assert property (bus_valid_o && bus_burst_o && burst_cnt == 4'h0 |->
        (line_short_i ? bus_addr_o[4:3] == 2'h0 : bus_addr_o[5:3] == 3'h0))
        else $error("burst does not start at chunk zero");
    a_burst_same_line: assert property (bus_valid_o && bus_burst_o && burst_cnt != 4'h0 |->
        bus_addr_o == burst_line + {25'h000_0000, burst_cnt, 3'h0})
        else $error("burst beat outside its line");
    a_burst_beat_count: assert property (beat_take && bus_burst_o && bus_last_o |->
        burst_cnt == (line_short_i ? 4'h3 : 4'h7))
        else $error("burst length wrong");
    a_partial_whole: assert property (bus_valid_o && !bus_burst_o |->
        burst_cnt == 4'h0 && bus_strb_o != 8'h00)
        else $error("partial beat empty or inside a burst");
    a_chunk_aligned: assert property (bus_valid_o |-> bus_addr_o[2:0] == 3'h0)
        else $error("beat address not chunk aligned");
    a_beat_hold: assert property (bus_valid_o && !bus_ready_i |=> bus_valid_o &&
        $stable(bus_addr_o) && $stable(bus_strb_o) && $stable(bus_data_o))
        else $error("beat changed before acceptance");
    a_store_ack: assert property (st_ready_o |-> $past(st_valid_i))
        else $error("store acknowledged without request");
    a_flush_drains: assert property (serialize_i |-> ##[1:600] drained_o)
        else $error("serialize not followed by drained");
    a_flush_refuses: assert property (flushing && $past(flushing) && !drained_o |->
        !st_ready_o)
        else $error("store taken during flush");
    a_drained_cause: assert property (drained_o |-> flushing)
        else $error("drained without serialize");

    c_burst: cover property (beat_take && bus_burst_o && bus_last_o);
    c_partial: cover property (beat_take && !bus_burst_o);
    c_drained: cover property (drained_o);
    c_refused: cover property ((st_valid_i && !st_ready_o) [*8]);
endmodule
`default_nettype wire
